//--- hw/cmp_ctrl_pkg.sv
// constants and types for the comparator control block
// Notes on behaviour
// - the result is high when the positive-side input is above the negative-side input, low otherwise.
// - the raw result passes a two-stage synchroniser before it is shown as the result status bit.
// - the event flag is set when the synchronised result makes the transition the event mode selects.
// - the event flag clears when its interrupt vector is taken or when software writes a one to it.
// - the comparator interrupt (cmpIrq) is requested only while flag, comparator enable and global enable are all set.
// - power is removed from the comparator while the power-off bit is one, writable at any time.
// - the bandgap reference replaces the positive input pin while the bandgap select bit is one.
// - while capture routing is one the result feeds the timer capture front end, otherwise nothing does.
// - event mode 00 is toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - with mux-negative enable set and the converter off, the converter mux picks the negative input.
// - in mux-negative mode channel select 000 to 111 picks analog channel 0 to 7.
// - the dedicated negative pin is used when mux-negative enable is zero or the converter is on.
// - the converter counts as on only while its converter enable bit is set.
package cmp_ctrl_pkg;

  // word byte addresses on the avalon slave
  localparam logic [3:0] CMP_CSR_ADDR = 4'h0;
  localparam logic [3:0] SPECIAL_FN_ADDR = 4'h4;
  localparam logic [3:0] CONV_CTRL_ADDR = 4'h8;
  localparam logic [3:0] IRQ_STATUS_ADDR = 4'hc;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'h0;

  // comparator control/status bit positions
  localparam int POWER_OFF_BIT = 7;
  localparam int BANDGAP_BIT = 6;
  localparam int RESULT_BIT = 5;
  localparam int FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int CAPTURE_BIT = 2;
  localparam int MODE_HI_BIT = 1;
  localparam int MODE_LO_BIT = 0;
  // special function register
  localparam int MUX_NEG_BIT = 3;
  // converter control: enable bit 7, channel select bits 2..0
  localparam int CONV_EN_BIT = 7;

  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALL = 2'b10,
    MODE_RISE = 2'b11
  } event_mode_t;

  typedef struct packed {
    logic cmpPowerOff;
    logic bandgapSelect;
    logic cmpIrqEnable;
    logic captureRouteEnable;
    event_mode_t eventMode;
  } cmp_cfg_t;

  typedef struct packed {
    logic muxNegativeEnable;
    logic converterEnable;
    logic [2:0] channelSelect;
  } neg_sel_t;

endpackage

//--- hw/comparator_irq_mux_control.sv
// comparator control, event flag, interrupt and avalon register file
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module comparator_irq_mux_control
  import cmp_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic posPinHigher,
  input wire logic [7:0] posChannelHigher,
  input wire logic bandgapHigher,
  input wire logic [7:0] bandgapChannelHigher,
  input wire logic globalIrqEnable,
  input wire logic vectorTaken,
  output logic cmpIrq,
  output logic irq,
  output logic cmpPowerOff,
  output logic bandgapEnable,
  output logic muxNegSelect,
  output logic captureIn
);

  ////////////////////////////////////////////////////////////////
  // registers
  cmp_cfg_t cfg_q;
  logic muxNeg_q;
  logic convEn_q;
  logic [2:0] chanSel_q;
  logic flag_q;
  logic resultPrev_q;
  logic stickyEvt_q;
  logic irqMask_q;
  logic ack_q;
  logic waitReq_q;
  logic [1:0] settle_q;
  logic [31:0] rdata_q;
  // edges are held off until the synchroniser and the previous-value flop hold real samples
  localparam logic [1:0] SETTLE_DONE = 2'b11;
  logic cmpIrq_q, irq_q, powerOff_q, bandgap_q, muxNegOut_q, capture_q;

  ////////////////////////////////////////////////////////////////
  // analog selection and synchroniser
  neg_sel_t negSel;
  logic useMux, rawResult, syncResult;
  assign negSel = '{muxNegativeEnable: muxNeg_q, converterEnable: convEn_q, channelSelect: chanSel_q};

  input_select #(.CHANNELS(8)) u_sel (
    .posPinHigher(posPinHigher),
    .posChannelHigher(posChannelHigher),
    .bandgapHigher(bandgapHigher),
    .bandgapChannelHigher(bandgapChannelHigher),
    .bandgapSelect(cfg_q.bandgapSelect),
    .negSel(negSel),
    .useMux(useMux),
    .rawResult(rawResult)
  );

  // the analog pins are asynchronous, so the result is synchronised before use
  result_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .rawIn(rawResult),
    .syncOut(syncResult)
  );

  ////////////////////////////////////////////////////////////////
  // bus decode; one wait cycle per access, answer on the second edge
  wire logic req = (read || write) && !ack_q;
  wire logic wrTake = write && ack_q;
  wire logic selCsr = address == CMP_CSR_ADDR;
  wire logic selSfn = address == SPECIAL_FN_ADDR;
  wire logic selConv = address == CONV_CTRL_ADDR;
  wire logic selStat = address == IRQ_STATUS_ADDR;
  wire logic lane0 = byteenable[0];
  wire logic csrWr = wrTake && selCsr && lane0;
  wire logic sfnWr = wrTake && selSfn && lane0;
  wire logic convWr = wrTake && selConv && lane0;
  wire logic statWr = wrTake && selStat && lane0;
  // mask sits at bit 8 of the status word so both stay in one word
  wire logic maskWr8 = wrTake && selStat && byteenable[1];

  ////////////////////////////////////////////////////////////////
  // edge detection
  wire logic rise = syncResult && !resultPrev_q;
  wire logic fall = !syncResult && resultPrev_q;
  logic evt;
  always_comb begin
    case (cfg_q.eventMode)
      MODE_TOGGLE: evt = rise || fall;
      MODE_FALL: evt = fall;
      MODE_RISE: evt = rise;
      default: evt = 1'b0;
    endcase
  end
  // without this gate a result that is high at reset would look like a rising edge
  wire logic evtLive = evt && (settle_q == SETTLE_DONE);
  // set beats clear when both land together
  wire logic flagClr = vectorTaken || (csrWr && writedata[FLAG_BIT]);
  wire logic flag_d = evtLive || (flag_q && !flagClr);
  wire logic stickyClr = statWr && writedata[0];
  wire logic sticky_d = evtLive || (stickyEvt_q && !stickyClr);
  wire logic cmpIrq_d = flag_d && cfg_q.cmpIrqEnable && globalIrqEnable;
  wire logic irq_d = sticky_d && irqMask_q;

  ////////////////////////////////////////////////////////////////
  // read mux
  wire logic [7:0] csrView = {cfg_q.cmpPowerOff, cfg_q.bandgapSelect, syncResult, flag_q,
                              cfg_q.cmpIrqEnable, cfg_q.captureRouteEnable, cfg_q.eventMode};
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = UNMAPPED_READ;
    if (selCsr) begin
      rdata_d = {24'h00_0000, csrView};
    end else if (selSfn) begin
      rdata_d = {28'h000_0000, muxNeg_q, 3'b000};
    end else if (selConv) begin
      rdata_d = {24'h00_0000, convEn_q, 4'h0, chanSel_q};
    end else if (selStat) begin
      rdata_d = {23'h00_0000, irqMask_q, 7'h00, stickyEvt_q};
    end
  end

  ////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      waitReq_q <= 1'b1;
      rdata_q <= UNMAPPED_READ;
    end else begin
      ack_q <= req;
      waitReq_q <= !req;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= 2'b00;
    end else if (settle_q != SETTLE_DONE) begin
      settle_q <= settle_q + 2'b01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= cmp_cfg_t'(6'h00);
    end else if (csrWr) begin
      // result bit is not stored, so writes to it fall away
      cfg_q.cmpPowerOff <= writedata[POWER_OFF_BIT];
      cfg_q.bandgapSelect <= writedata[BANDGAP_BIT];
      cfg_q.cmpIrqEnable <= writedata[IRQ_EN_BIT];
      cfg_q.captureRouteEnable <= writedata[CAPTURE_BIT];
      cfg_q.eventMode <= event_mode_t'(writedata[MODE_HI_BIT:MODE_LO_BIT]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      muxNeg_q <= 1'b0;
      convEn_q <= 1'b0;
      chanSel_q <= 3'b000;
    end else begin
      if (sfnWr) muxNeg_q <= writedata[MUX_NEG_BIT];
      if (convWr) begin
        convEn_q <= writedata[CONV_EN_BIT];
        chanSel_q <= writedata[2:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resultPrev_q <= 1'b0;
      flag_q <= 1'b0;
      stickyEvt_q <= 1'b0;
      irqMask_q <= 1'b0;
    end else begin
      resultPrev_q <= syncResult;
      flag_q <= flag_d;
      stickyEvt_q <= sticky_d;
      if (maskWr8) irqMask_q <= writedata[8];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmpIrq_q <= 1'b0;
      irq_q <= 1'b0;
      powerOff_q <= 1'b0;
      bandgap_q <= 1'b0;
      muxNegOut_q <= 1'b0;
      capture_q <= 1'b0;
    end else begin
      cmpIrq_q <= cmpIrq_d;
      irq_q <= irq_d;
      powerOff_q <= cfg_q.cmpPowerOff;
      bandgap_q <= cfg_q.bandgapSelect;
      muxNegOut_q <= useMux;
      capture_q <= cfg_q.captureRouteEnable && syncResult;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = waitReq_q;
  assign cmpIrq = cmpIrq_q;
  assign irq = irq_q;
  assign cmpPowerOff = powerOff_q;
  assign bandgapEnable = bandgap_q;
  assign muxNegSelect = muxNegOut_q;
  assign captureIn = capture_q;

endmodule // comparator_irq_mux_control

//--- hw/input_select.sv
// analog input selection and comparison model
`timescale 1ns/1ps
module input_select
  import cmp_ctrl_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic posPinHigher,
  input wire logic [CHANNELS-1:0] posChannelHigher,
  input wire logic bandgapHigher,
  input wire logic [CHANNELS-1:0] bandgapChannelHigher,
  input wire logic bandgapSelect,
  input wire neg_sel_t negSel,
  output logic useMux,
  output logic rawResult
);
  // the comparator itself is analog; each input pair arrives as a precomputed greater-than
  wire logic convOn = negSel.converterEnable;
  assign useMux = negSel.muxNegativeEnable && !convOn;
  wire logic posVsPin = bandgapSelect ? bandgapHigher : posPinHigher;
  wire logic posVsChan = bandgapSelect ? bandgapChannelHigher[negSel.channelSelect]
                                        : posChannelHigher[negSel.channelSelect];
  assign rawResult = useMux ? posVsChan : posVsPin;
endmodule // input_select

//--- hw/result_sync.sv
// two-flop synchroniser for the comparator result
`timescale 1ns/1ps
module result_sync
  import cmp_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rawIn,
  output logic syncOut
);
  logic meta_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= rawIn;
      syncOut <= meta_q;
    end
  end
endmodule // result_sync

//--- tb/analog_core.sv
// behavioural analog comparator core facing the control block
`timescale 1ns/1ps
module analog_core (
  input wire logic [7:0] posV,
  input wire logic [7:0] negV,
  input wire logic [7:0] bgV,
  input wire logic [63:0] chV,
  output logic posPinHigher,
  output logic bandgapHigher,
  output logic [7:0] posChannelHigher,
  output logic [7:0] bandgapChannelHigher
);
  // all pairings compared at once, equal voltages read low; the block only selects
  always_comb begin
    posPinHigher = posV > negV;
    bandgapHigher = bgV > negV;
    for (int i = 0; i < 8; i++) begin
      posChannelHigher[i] = posV > chV[i*8 +: 8];
      bandgapChannelHigher[i] = bgV > chV[i*8 +: 8];
    end
  end
endmodule // analog_core

//--- tb/cmp_ctrl_props.sv
// assertion checker for the comparator control block
`timescale 1ns/1ps
module cmp_ctrl_props
  import cmp_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic globalIrqEnable,
  input wire logic vectorTaken,
  input wire logic cmpIrq,
  input wire logic irq,
  input wire logic cmpPowerOff,
  input wire logic bandgapEnable,
  input wire logic muxNegSelect,
  input wire logic captureIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wrDone = write && !waitrequest && byteenable[0];
  wire csrWr = wrDone && address == CMP_CSR_ADDR;
  ////////////////////////////////////////////////////////////////////////
  a_wait_one:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer after one wait");
  a_unmapped_zero:
    assert property (read && !waitrequest && address[1:0] != 2'b00 |-> readdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_power_follows:
    assert property (csrWr |-> ##2 cmpPowerOff == $past(writedata[POWER_OFF_BIT], 2)) else $error("power-off not taken");
  a_bandgap_follows:
    assert property (csrWr |-> ##2 bandgapEnable == $past(writedata[BANDGAP_BIT], 2)) else $error("bandgap not taken");
  a_capture_gated:
    assert property (csrWr && !writedata[CAPTURE_BIT] |=> ##2 !captureIn) else $error("capture not cut off");
  a_global_gate:
    assert property (cmpIrq |-> $past(globalIrqEnable)) else $error("cmp irq without global enable");
  a_vector_clears:
    assert property (vectorTaken |=> ##1 !cmpIrq) else $error("vector did not clear flag");
  a_conv_on_pin:
    assert property (wrDone && address == CONV_CTRL_ADDR && writedata[CONV_EN_BIT] |=> ##2 !muxNegSelect)
    else $error("mux kept while converter on");
  a_mask_blocks:
    assert property (write && !waitrequest && byteenable[1] && address == IRQ_STATUS_ADDR && !writedata[8]
      |=> ##2 !irq) else $error("masked irq raised");
  c_cmp_irq: cover property (cmpIrq && irq);
  c_capture: cover property (captureIn);
  c_mux_sel: cover property (muxNegSelect);
endmodule // cmp_ctrl_props
bind comparator_irq_mux_control cmp_ctrl_props props (.*);

//--- tb/testbench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench;
  import cmp_ctrl_pkg::*;
  logic clk = 0, rst_b = 0, read = 0, write = 0, globalIrqEnable = 0, vectorTaken = 0;
  logic [3:0] address = 4'h0, byteenable = 4'h3;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd, w;
  logic waitrequest, posPinHigher, bandgapHigher, cmpIrq, irq, cmpPowerOff, bandgapEnable, muxNegSelect, captureIn;
  logic [7:0] posChannelHigher, bandgapChannelHigher, posV = 8'h64, negV = 8'h32, bgV = 8'hc8, cfg = 8'h00, conv = 8'h00;
  logic [63:0] chV = 64'h0000_0000_0000_0000;
  logic flg = 0, sts = 0, msk = 0, mux = 0, glob, ev;
  logic capIrqEnable = 0, capIrq = 0;
  int err_count = 0, checks = 0;
  always #5 clk = ~clk;
  // timer side: a comparator capture raises the capture interrupt only with its own enable set
  always @(posedge clk) capIrq <= capIrqEnable & captureIn;
  analog_core ana (.*);
  comparator_irq_mux_control DUT (.*);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic res();
    logic [7:0] p, n;
    p = cfg[BANDGAP_BIT] ? bgV : posV;
    n = (mux && !conv[CONV_EN_BIT]) ? chV[conv[2:0]*8 +: 8] : negV;
    return p > n;
  endfunction
  function automatic logic [31:0] csrExp();
    return {24'h0, cfg[7:6], res(), flg, cfg[3:0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until waitrequest is seen low; the watchdog bounds the wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 0;
    read <= 0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(40));
    repeat (2) @(posedge clk);
    rst_b <= 1;
    // let the synchroniser fill before the result bit is read back
    repeat (2) @(posedge clk);
    for (int a = 0; a < 16; a += 2) begin
      bus(0, a[3:0], 0);
      chk("reset read", (a == 0) ? csrExp() : 32'h0, rd);
    end
    $display("reset reads done");
    repeat (4) begin
      w = $urandom & 32'hffff_fff7; // interrupt kept off while power-off changes
      bus(1, CMP_CSR_ADDR, w);
      cfg = w[7:0] & 8'hcf;
      bus(0, CMP_CSR_ADDR, 0);
      chk("csr", csrExp(), rd);
      chk("power off", cfg[7], cmpPowerOff);
      chk("bandgap", cfg[6], bandgapEnable);
    end
    $display("random csr done");
    for (int m = 0; m < 4; m++) begin
      glob = (m != 1);
      msk = m[0];
      globalIrqEnable <= glob;
      cfg = m;
      bus(1, CMP_CSR_ADDR, {24'h0, cfg} | 32'h10); // mode changed with interrupt off
      cfg = cfg | 8'h08;
      bus(1, CMP_CSR_ADDR, cfg);
      bus(1, IRQ_STATUS_ADDR, {msk, 8'h01});
      flg = 0;
      sts = 0;
      for (int e = 0; e < 2; e++) begin
        posV <= e ? 8'h64 : 8'h00;
        repeat (6) @(posedge clk);
        ev = (m == 0) || (m == (e ? 3 : 2));
        flg = flg | ev;
        sts = sts | ev;
        bus(0, CMP_CSR_ADDR, 0);
        chk("flag", csrExp(), rd);
        bus(0, IRQ_STATUS_ADDR, 0);
        chk("status", {msk, 7'h0, sts}, rd);
        chk("cmp irq", flg & glob, cmpIrq);
        chk("irq", sts & msk, irq);
        if (e) bus(1, CMP_CSR_ADDR, {24'h0, cfg} | 32'h10);
        else begin
          vectorTaken <= 1;
          @(posedge clk);
          vectorTaken <= 0;
        end
        flg = 0;
        repeat (2) @(posedge clk);
        chk("flag cleared", 0, cmpIrq);
      end
      $display("event mode %0d done", m);
    end
    mux = 1;
    bus(1, SPECIAL_FN_ADDR, 32'h8);
    for (int c = 0; c < 8; c++) begin
      w = $urandom;
      posV <= w[7:0];
      chV[c*8 +: 8] <= w[15:8];
      cfg = {1'b0, c[0], 6'h04};
      conv = c;
      bus(1, CMP_CSR_ADDR, cfg);
      bus(1, CONV_CTRL_ADDR, conv);
      repeat (4) @(posedge clk);
      bus(0, CMP_CSR_ADDR, 0);
      chk("channel result", res(), rd[RESULT_BIT]);
      chk("capture", res(), captureIn);
      chk("mux select", 1, muxNegSelect);
    end
    capIrqEnable <= 1;
    conv = 8'h87;
    bus(1, CONV_CTRL_ADDR, conv);
    repeat (4) @(posedge clk);
    bus(0, CMP_CSR_ADDR, 0);
    chk("pin result", res(), rd[RESULT_BIT]);
    chk("mux off", 0, muxNegSelect);
    chk("capture irq", res(), capIrq);
    $display("mux and capture done");
    give_verdict();
  end
endmodule // testbench
